// *** src/loopback_fifo.v ***
`timescale 1ns/1ps
`include "phy_power_save_consts.vh"
// ------------------------------------------------------------
// Elastic buffer for far-end loopback
// ------------------------------------------------------------
module loopback_fifo #(
  parameter WIDTH = 4,
  parameter DEPTH = 8
) (
  input wire sys_clk_i,
  input wire reset_i,
  input wire [1:0] depth_sel_i,
  input wire wr_en_i,
  input wire [WIDTH-1:0] wr_data_i,
  input wire rd_en_i,
  output reg [WIDTH-1:0] rd_data_o,
  output reg rd_valid_o
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [2:0] wr_ptr_r;
  reg [2:0] rd_ptr_r;
  reg [3:0] level_r;
  reg started_r;
  reg [3:0] fill_target;
  wire do_wr;
  wire do_rd;
  integer i;

  // Selected depth in nibbles
  always @* begin
    case (depth_sel_i)
      2'h0: fill_target = 4'h4;
      2'h1: fill_target = 4'h5;
      2'h2: fill_target = 4'h6;
      default: fill_target = 4'h8;
    endcase
  end

  assign do_wr = wr_en_i && (level_r < fill_target);
  // Reading starts once the buffer has filled to the selected depth
  assign do_rd = rd_en_i && started_r && (level_r != 4'h0);

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_r <= 3'h0;
      rd_ptr_r <= 3'h0;
      level_r <= 4'h0;
      started_r <= 1'b0;
      rd_data_o <= {WIDTH{1'b0}};
      rd_valid_o <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_r[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (do_wr) begin
        mem_r[wr_ptr_r] <= wr_data_i;
        wr_ptr_r <= wr_ptr_r + 3'h1;
      end
      if (do_rd) begin
        rd_data_o <= mem_r[rd_ptr_r];
        rd_ptr_r <= rd_ptr_r + 3'h1;
      end
      rd_valid_o <= do_rd;
      level_r <= level_r + {3'h0, do_wr} - {3'h0, do_rd};
      if (level_r >= fill_target) begin
        started_r <= 1'b1;
      end else if (level_r == 4'h0 && !wr_en_i) begin
        started_r <= 1'b0;
      end
    end
  end
endmodule // loopback_fifo

// *** src/phy_power_save_consts.vh ***
`ifndef PHY_POWER_SAVE_CONSTS_VH
`define PHY_POWER_SAVE_CONSTS_VH
// Register index 0x11 is not word aligned; the byte address is four times it
`define PSC_REG_INDEX 8'h11
`define PSC_REG_ADDR 12'h044
`define PSC_STATUS_ADDR 12'h048
// Field positions
`define PSC_CLK_DIS_BIT 15
`define PSC_PS_EN_BIT 14
`define PSC_MODE_HI 13
`define PSC_MODE_LO 12
`define PSC_SCR_BYP_BIT 11
`define PSC_FIFO_HI 9
`define PSC_FIFO_LO 8
`define PSC_COL_FD_BIT 4
// Reset values
`define PSC_MODE_RST 2'h0
`define PSC_FIFO_RST 2'h1
// Mode codes
`define PSC_MODE_NORMAL 2'h0
`define PSC_MODE_PWRDN 2'h1
`define PSC_MODE_ACTIVE 2'h2
`define PSC_MODE_PASSIVE 2'h3
// Link pulse period: 1.4 s in ms, and cycles at 25 ns
`define PSC_NLP_PERIOD_MS 1400
`define PSC_CLK_PERIOD_NS 25
`define PSC_NLP_CYCLES ((`PSC_NLP_PERIOD_MS * 1000000) / `PSC_CLK_PERIOD_NS)
`endif

// *** src/phy_power_save_control.v ***
`timescale 1ns/1ps
`include "phy_power_save_consts.vh"
module phy_power_save_control #(
  parameter NLP_CYCLES = `PSC_NLP_CYCLES
) (
  input wire sys_clk_i,
  input wire reset_i,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire energy_detect_i,
  input wire full_duplex_i,
  input wire collision_raw_i,
  input wire far_end_loopback_i,
  input wire rx_nibble_valid_i,
  input wire [3:0] rx_nibble_i,
  input wire tx_nibble_req_i,
  output reg clocks_off_o,
  output reg analog_power_down_o,
  output reg energy_detect_on_o,
  output reg link_pulse_o,
  output reg scrambler_bypass_o,
  output reg collision_o,
  output reg [3:0] loop_nibble_o,
  output reg loop_nibble_valid_o
);
  // ------------------------------------------------------------
  // Power states, one-hot
  // ------------------------------------------------------------
  localparam ST_RUN = 4'b0001;
  localparam ST_PWRDN = 4'b0010;
  localparam ST_ACTIVE = 4'b0100;
  localparam ST_PASSIVE = 4'b1000;

  reg clk_dis_r;
  reg power_save_enable_r;
  reg [1:0] power_save_mode_select_r;
  reg scr_bypass_r;
  reg [1:0] fifo_depth_r;
  reg full_duplex_collision_enable_r;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg wake_on_link_r;
  reg [31:0] nlp_cnt_r;
  reg [15:0] reg_value;
  reg [31:0] rd_value;
  wire [3:0] fifo_data;
  wire fifo_valid;
  wire setup;
  wire wr_ctl;

  assign setup = psel && !penable;
  assign wr_ctl = psel && penable && pready && pwrite && (paddr == `PSC_REG_ADDR);

  // ------------------------------------------------------------
  // Register read value
  // ------------------------------------------------------------
  always @* begin
    reg_value = 16'h0000;
    reg_value[`PSC_CLK_DIS_BIT] = clk_dis_r;
    reg_value[`PSC_PS_EN_BIT] = power_save_enable_r;
    reg_value[`PSC_MODE_HI:`PSC_MODE_LO] = power_save_mode_select_r;
    reg_value[`PSC_SCR_BYP_BIT] = scr_bypass_r;
    reg_value[`PSC_FIFO_HI:`PSC_FIFO_LO] = fifo_depth_r;
    reg_value[`PSC_COL_FD_BIT] = full_duplex_collision_enable_r;
  end

  always @* begin
    rd_value = 32'h00000000;
    if (paddr == `PSC_REG_ADDR) begin
      rd_value = {16'h0000, reg_value};
    end else if (paddr == `PSC_STATUS_ADDR) begin
      rd_value = {27'h0000000, wake_on_link_r, state_r};
    end
  end

  // ------------------------------------------------------------
  // APB slave: no wait states, error on unmapped address
  // ------------------------------------------------------------
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && (paddr != `PSC_REG_ADDR) && (paddr != `PSC_STATUS_ADDR);
      if (setup && !pwrite) begin
        prdata <= rd_value;
      end
    end
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      clk_dis_r <= 1'b0;
      power_save_enable_r <= 1'b0;
      power_save_mode_select_r <= `PSC_MODE_RST;
      scr_bypass_r <= 1'b0;
      fifo_depth_r <= `PSC_FIFO_RST;
      full_duplex_collision_enable_r <= 1'b0;
    end else if (wr_ctl) begin
      clk_dis_r <= pwdata[`PSC_CLK_DIS_BIT];
      power_save_enable_r <= pwdata[`PSC_PS_EN_BIT];
      power_save_mode_select_r <= pwdata[`PSC_MODE_HI:`PSC_MODE_LO];
      scr_bypass_r <= pwdata[`PSC_SCR_BYP_BIT];
      fifo_depth_r <= pwdata[`PSC_FIFO_HI:`PSC_FIFO_LO];
      full_duplex_collision_enable_r <= pwdata[`PSC_COL_FD_BIT];
    end else if (state_r == ST_RUN && wake_on_link_r) begin
      // Leaving sleep clears the enable so the device stays awake
      power_save_enable_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Power state machine
  // ------------------------------------------------------------
  always @* begin
    state_nxt = ST_RUN;
    if (power_save_enable_r) begin
      case (power_save_mode_select_r)
        `PSC_MODE_PWRDN: state_nxt = ST_PWRDN;
        `PSC_MODE_ACTIVE: state_nxt = ST_ACTIVE;
        `PSC_MODE_PASSIVE: state_nxt = ST_PASSIVE;
        default: state_nxt = ST_RUN;
      endcase
    end
    case (state_r)
      ST_ACTIVE, ST_PASSIVE: begin
        if (energy_detect_i) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
      end
    endcase
  end

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= ST_RUN;
      wake_on_link_r <= 1'b0;
    end else begin
      if (wr_ctl) begin
        state_r <= ST_RUN;
        wake_on_link_r <= 1'b0;
      end else if (wake_on_link_r) begin
        state_r <= ST_RUN;
        wake_on_link_r <= 1'b0;
      end else begin
        state_r <= state_nxt;
        wake_on_link_r <= (state_r == ST_ACTIVE || state_r == ST_PASSIVE) && energy_detect_i;
      end
    end
  end

  // ------------------------------------------------------------
  // Link pulse timer and power outputs
  // ------------------------------------------------------------
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      nlp_cnt_r <= 32'h00000000;
      link_pulse_o <= 1'b0;
      clocks_off_o <= 1'b0;
      analog_power_down_o <= 1'b0;
      energy_detect_on_o <= 1'b0;
      scrambler_bypass_o <= 1'b0;
      collision_o <= 1'b0;
    end else begin
      link_pulse_o <= 1'b0;
      if (state_r != ST_ACTIVE) begin
        nlp_cnt_r <= 32'h00000000;
      end else if (nlp_cnt_r == NLP_CYCLES - 1) begin
        nlp_cnt_r <= 32'h00000000;
        link_pulse_o <= 1'b1;
      end else begin
        nlp_cnt_r <= nlp_cnt_r + 32'h00000001;
      end
      clocks_off_o <= clk_dis_r && (state_r == ST_PWRDN);
      analog_power_down_o <= (state_r != ST_RUN);
      energy_detect_on_o <= (state_r == ST_ACTIVE) || (state_r == ST_PASSIVE);
      scrambler_bypass_o <= scr_bypass_r;
      collision_o <= collision_raw_i && (!full_duplex_i || full_duplex_collision_enable_r);
    end
  end

  // ------------------------------------------------------------
  // Far-end loopback path
  // ------------------------------------------------------------
  loopback_fifo #(
    .WIDTH(4),
    .DEPTH(8)
  ) u_loop_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .depth_sel_i(fifo_depth_r),
    .wr_en_i(far_end_loopback_i && rx_nibble_valid_i),
    .wr_data_i(rx_nibble_i),
    .rd_en_i(far_end_loopback_i && tx_nibble_req_i),
    .rd_data_o(fifo_data),
    .rd_valid_o(fifo_valid)
  );

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      loop_nibble_o <= 4'h0;
      loop_nibble_valid_o <= 1'b0;
    end else begin
      loop_nibble_o <= fifo_data;
      loop_nibble_valid_o <= fifo_valid;
    end
  end
endmodule // phy_power_save_control

// *** verification/phy_power_save_checker.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module phy_power_save_checker #(parameter NLP_CYCLES = 20) (
  input wire sys_clk_i,
  input wire reset_i,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire energy_detect_i,
  input wire full_duplex_i,
  input wire collision_raw_i,
  input wire clocks_off_o,
  input wire analog_power_down_o,
  input wire energy_detect_on_o,
  input wire link_pulse_o,
  input wire scrambler_bypass_o,
  input wire collision_o
);
  reg col_fd_r, scr_r, seen_r;
  reg [31:0] gap_r;
  wire acc = psel && penable && pready;
  wire wr_hit = acc && pwrite && paddr == 12'h044;
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      col_fd_r <= 1'h0;
      scr_r <= 1'h0;
      seen_r <= 1'h0;
      gap_r <= 32'h0;
    end else begin
      if (wr_hit) begin
        col_fd_r <= pwdata[4];
        scr_r <= pwdata[11];
      end
      gap_r <= link_pulse_o ? 32'h1 : gap_r + 32'h1;
      seen_r <= (seen_r || link_pulse_o) && energy_detect_on_o && !wr_hit;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_setup; psel && !penable; endsequence
  sequence s_wake; energy_detect_on_o && energy_detect_i; endsequence
  chk_apb_ready: assert property (s_setup |=> pready)
    else $error("access not answered");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_slv_err: assert property (acc |-> pslverr == (paddr != 12'h044 && paddr != 12'h048))
    else $error("wrong slave error");
  chk_rsv_zero: assert property (acc && !pwrite && paddr == 12'h044 |-> (prdata & 32'hffff04e0) == 32'h0)
    else $error("reserved bits set");
  chk_scr_follow: assert property (wr_hit |-> ##2 scrambler_bypass_o == scr_r)
    else $error("bypass output wrong");
  chk_col_gate: assert property (!$past(reset_i) |-> collision_o == $past(collision_raw_i && (!full_duplex_i || col_fd_r)))
    else $error("collision output wrong");
  chk_clk_off: assert property (clocks_off_o |-> analog_power_down_o && !energy_detect_on_o)
    else $error("clocks off outside power down");
  chk_pulse_sleep: assert property (link_pulse_o |-> energy_detect_on_o ##1 !link_pulse_o)
    else $error("link pulse outside sleep");
  chk_pulse_gap: assert property (link_pulse_o && seen_r |-> gap_r == NLP_CYCLES)
    else $error("link pulse spacing wrong");
  chk_wake_up: assert property (s_wake |-> ##[1:3] !analog_power_down_o)
    else $error("no wake on energy");
endmodule // phy_power_save_checker
bind phy_power_save_control phy_power_save_checker #(.NLP_CYCLES(NLP_CYCLES)) phy_power_save_checker_i (.*);

// *** verification/test_phy_power_save_control.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Testbench
// ----------------------------------------
module test_phy_power_save_control;
  logic sys_clk_i = 1'h0, reset_i = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, x;
  logic energy_detect_i = 1'h0, full_duplex_i = 1'h0, collision_raw_i = 1'h0, far_end_loopback_i = 1'h0;
  logic rx_nibble_valid_i = 1'h0, tx_nibble_req_i = 1'h0, b4;
  logic [3:0] rx_nibble_i = 4'h0, loop_nibble_o;
  logic [31:0] prdata;
  logic pready, pslverr, clocks_off_o, analog_power_down_o, energy_detect_on_o;
  logic link_pulse_o, scrambler_bypass_o, collision_o, loop_nibble_valid_o;
  int err_total = 0, n_compared = 0, cyc = 0, npulse = 0, k, m;
  logic [32:0] rd_q[$], e;
  logic [3:0] nib_q[$], nv[8];
  phy_power_save_control #(.NLP_CYCLES(20)) phy_power_save_control_i (.*);
  always #12.5 sys_clk_i = ~sys_clk_i;
  task chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_rd(input logic [32:0] got, input logic [32:0] exp);
    chk(got, exp);
  endtask
  task chk_nib(input logic [3:0] got, input logic [3:0] exp);
    chk({29'h0, got}, {29'h0, exp});
  endtask
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] r);
    int n;
    if (!wr) rd_q.push_back(r);
    @(posedge sys_clk_i);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'h1;
    n = 0;
    // Access phase lasts until pready is seen high at a rising edge
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) err_total++;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // ----------------------------------------
  // Result monitor and timeout
  // ----------------------------------------
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (link_pulse_o === 1'h1) npulse <= npulse + 1;
    if (psel && penable && pready === 1'h1 && !pwrite) chk_rd({pslverr, prdata}, rd_q.pop_front());
    if (loop_nibble_valid_o === 1'h1) chk_nib(loop_nibble_o, nib_q.pop_front());
    if (cyc == 20000) begin
      err_total++;
      give_verdict;
    end
  end
  initial begin
    void'($urandom(92));
    repeat (12) @(posedge sys_clk_i);
    reset_i <= 1'h0;
    apb(1'h0, 12'h044, 32'h0, 33'h100);
    chk(analog_power_down_o, 33'h0);
    apb(1'h1, 12'h044, 32'hfffffff0, 33'h0);
    apb(1'h0, 12'h044, 32'h0, 33'hfb10);
    chk(scrambler_bypass_o, 33'h1);
    apb(1'h1, 12'h100, 32'hffff, 33'h0);
    apb(1'h0, 12'h100, 32'h0, 33'h100000000);
    for (int i = 0; i < 16; i++) begin
      x = {16'h0, i[3], i[2], i[1:0], 12'h100};
      apb(1'h1, 12'h044, x, 33'h0);
      repeat (3) @(posedge sys_clk_i);
      #1;
      chk(clocks_off_o, i[3] && i[2] && i[1:0] == 2'h1);
      chk(analog_power_down_o, i[2] && i[1:0] != 2'h0);
      chk(energy_detect_on_o, i[2] && i[1]);
      npulse = 0;
      repeat (50) @(posedge sys_clk_i);
      chk(npulse, (i[2] && i[1:0] == 2'h2) ? 2 : 0);
    end
    apb(1'h1, 12'h044, 32'h6100, 33'h0);
    repeat (3) @(posedge sys_clk_i);
    energy_detect_i <= 1'h1;
    repeat (5) @(posedge sys_clk_i);
    energy_detect_i <= 1'h0;
    #1;
    chk(analog_power_down_o, 33'h0);
    apb(1'h0, 12'h044, 32'h0, 33'h2100);
    for (k = 0; k < 200; k++) begin
      if (k % 100 == 0) begin
        b4 = k > 0;
        apb(1'h1, 12'h044, {27'h0, b4, 4'h0}, 33'h0);
      end
      @(posedge sys_clk_i);
      e = collision_raw_i && (!full_duplex_i || b4);
      {full_duplex_i, collision_raw_i} <= 2'($urandom);
      #1;
      chk(collision_o, e);
    end
    // Each depth: a request one nibble short of full yields nothing, then all nibbles drain in order
    for (int d = 0; d < 4; d++) begin
      m = (d == 3) ? 8 : d + 4;
      apb(1'h1, 12'h044, {22'h0, d[1:0], 8'h0}, 33'h0);
      far_end_loopback_i <= 1'h1;
      for (k = 0; k < m; k++) begin
        if (k == m - 1) begin
          @(posedge sys_clk_i);
          rx_nibble_valid_i <= 1'h0;
          tx_nibble_req_i <= 1'h1;
          @(posedge sys_clk_i);
          tx_nibble_req_i <= 1'h0;
        end
        @(posedge sys_clk_i);
        nv[k] = 4'($urandom);
        rx_nibble_valid_i <= 1'h1;
        rx_nibble_i <= nv[k];
      end
      @(posedge sys_clk_i);
      rx_nibble_valid_i <= 1'h0;
      repeat (2) @(posedge sys_clk_i);
      for (k = 0; k < m; k++) begin
        nib_q.push_back(nv[k]);
        tx_nibble_req_i <= 1'h1;
        @(posedge sys_clk_i);
      end
      tx_nibble_req_i <= 1'h0;
      far_end_loopback_i <= 1'h0;
      repeat (4) @(posedge sys_clk_i);
      chk(nib_q.size(), 33'h0);
    end
    give_verdict;
  end
endmodule // test_phy_power_save_control
